// ==== hw/smcg_top.sv ====
`timescale 1ns/1ps
module smcg_top
(
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire logic [2:0]                            sleep_mode_select,
    input  wire logic                                  sleep_enable_bit,
    input  wire logic                                  sleep_instr,
    input  wire logic [smcg_pkg::PERIPH_COUNT-1:0]     power_reduction_bits,
    input  wire logic [smcg_pkg::PERIPH_COUNT-1:0]     periph_access,
    input  wire logic [3:0]                            clock_source_select_fuses,
    input  wire logic [1:0]                            startup_time_fuses,
    input  wire logic                                  brownout_level_fuses,
    input  wire logic                                  brownout_sleep_off,
    input  wire logic                                  debug_system_fuse,
    input  wire logic                                  scan_port_enable_fuse,
    input  wire logic                                  debug_port_disable,
    input  wire logic                                  global_irq_enable,
    input  wire logic [1:0]                            async_timer_interrupt_mask,
    input  wire logic [1:0]                            async_timer_event,
    input  wire logic                                  async_timer_async,
    input  wire logic                                  async_timer_enable,
    input  wire logic                                  converter_enable,
    input  wire logic                                  converter_done,
    input  wire logic                                  comparator_enable,
    input  wire logic                                  comparator_uses_ref,
    input  wire logic                                  ext_reset_wake,
    input  wire logic                                  watchdog_reset_wake,
    input  wire logic                                  watchdog_irq_wake,
    input  wire logic                                  brownout_reset_wake,
    input  wire logic                                  two_wire_match,
    input  wire logic                                  mem_ready_irq,
    input  wire logic                                  ext_level_irq,
    input  wire logic                                  pin_change_irq,
    output logic                                       clk_cpu_en,
    output logic                                       clk_flash_en,
    output logic                                       clk_io_en,
    output logic                                       clk_adc_en,
    output logic                                       clk_async_en,
    output logic                                       main_osc_en,
    output logic                                       timer_osc_en,
    output logic                                       timer_sync_clk_en,
    output logic [smcg_pkg::PERIPH_COUNT-1:0]          periph_clk_en,
    output logic [smcg_pkg::PERIPH_COUNT-1:0]          periph_access_ok,
    output logic                                       converter_on,
    output logic                                       converter_extended,
    output logic                                       comparator_on,
    output logic                                       brownout_on,
    output logic                                       vref_on,
    output logic                                       input_buf_en,
    output logic                                       irq_raise,
    output logic                                       cpu_resume,
    output logic [2:0]                                 active_mode
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        smcg_pkg::smcg_state_e st;
        logic [2:0]            mode;
        logic [7:0]            cnt;
        logic                  irq_wake;
        logic                  conv_prev;
        logic                  conv_ext;
        logic [2:0]            ext_rst;
        logic [2:0]            ext_tw;
        logic                  clk_cpu_en;
        logic                  clk_flash_en;
        logic                  clk_io_en;
        logic                  clk_adc_en;
        logic                  clk_async_en;
        logic                  main_osc_en;
        logic                  timer_osc_en;
        logic                  timer_sync_clk_en;
        logic [smcg_pkg::PERIPH_COUNT-1:0] periph_clk_en;
        logic [smcg_pkg::PERIPH_COUNT-1:0] periph_access_ok;
        logic                  converter_on;
        logic                  comparator_on;
        logic                  brownout_on;
        logic                  vref_on;
        logic                  input_buf_en;
        logic                  irq_raise;
        logic                  cpu_resume;
    } smcg_state_s;

    smcg_state_s r;
    smcg_state_s next_r;
    smcg_wake_if w ();

    assign w.mode           = r.mode;
    assign w.asleep         = (r.st == smcg_pkg::SMCG_SLEEP);
    assign w.timer_async    = async_timer_async;
    assign w.level_irq_raw  = ext_level_irq;
    assign w.pin_change_raw = pin_change_irq;

    smcg_pin_sync u_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .w     (w)
    );

    // ****************************************
    // Mode decode and wake qualification
    // ****************************************
    logic       mode_legal;
    logic       crystal;
    logic       timer_wake;
    logic       any_wake;
    logic       deep;
    logic       timer_kept;
    logic       next_deep;
    logic       debug_keep;
    logic [7:0] startup_cycles;

    always_comb
    begin
        crystal    = (clock_source_select_fuses >= smcg_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN);
        mode_legal = (sleep_mode_select == smcg_pkg::MODE_IDLE)
            || (sleep_mode_select == smcg_pkg::MODE_NOISE)
            || (sleep_mode_select == smcg_pkg::MODE_PDOWN)
            || (sleep_mode_select == smcg_pkg::MODE_PSAVE)
            || ((sleep_mode_select == smcg_pkg::MODE_STANDBY) && crystal)
            || ((sleep_mode_select == smcg_pkg::MODE_EXTSTBY) && crystal);
        deep       = (r.mode != smcg_pkg::MODE_IDLE) && (r.mode != smcg_pkg::MODE_NOISE);
        timer_kept = async_timer_enable && ((r.mode == smcg_pkg::MODE_PSAVE)
            || (r.mode == smcg_pkg::MODE_EXTSTBY)
            || ((r.mode == smcg_pkg::MODE_NOISE) && async_timer_async)
            || (r.mode == smcg_pkg::MODE_IDLE));
        // Timer event wakes only with its own enables and the global enable
        timer_wake = timer_kept && global_irq_enable
            && |(async_timer_event & async_timer_interrupt_mask);
        // Resets, watchdog, two-wire match and wake pins always wake; timer, memory-ready and converter depend on mode
        any_wake   = r.ext_rst[2] || watchdog_reset_wake || watchdog_irq_wake
            || brownout_reset_wake || r.ext_tw[2] || w.wake_hit || timer_wake;
        if (!deep)
        begin
            any_wake = any_wake || mem_ready_irq || converter_done;
        end
        debug_keep = debug_system_fuse && scan_port_enable_fuse && !debug_port_disable;
        // Start-up scaled by fuses; long fuse startup delays are shortened for area
        startup_cycles = 8'({clock_source_select_fuses, startup_time_fuses} << smcg_pkg::STARTUP_SCALE_SHIFT)
            + smcg_pkg::STANDBY_WAKE_CYCLES;
    end

    // ****************************************
    // Sequencer and clock tree
    // ****************************************
    always_comb
    begin
        next_r            = r;
        next_r.irq_raise  = 1'b0;
        next_r.cpu_resume = 1'b0;
        next_r.ext_rst    = {r.ext_rst[1:0], ext_reset_wake};
        next_r.ext_tw     = {r.ext_tw[1:0], two_wire_match};
        case (r.st)
            smcg_pkg::SMCG_ACTIVE:
            begin
                // Sleep needs both the enable bit and the instruction
                if (sleep_instr && sleep_enable_bit && mode_legal)
                begin
                    next_r.st   = smcg_pkg::SMCG_SLEEP;
                    next_r.mode = sleep_mode_select;
                end
            end
            smcg_pkg::SMCG_SLEEP:
            begin
                if (any_wake)
                begin
                    next_r.irq_wake = !(r.ext_rst[2] || watchdog_reset_wake || brownout_reset_wake);
                    next_r.st       = smcg_pkg::SMCG_STARTUP;
                    if ((r.mode == smcg_pkg::MODE_STANDBY) || (r.mode == smcg_pkg::MODE_EXTSTBY)
                        || !deep)
                    begin
                        next_r.cnt = smcg_pkg::STANDBY_WAKE_CYCLES - 8'h01;
                    end
                    else
                    begin
                        next_r.cnt = startup_cycles;
                    end
                end
            end
            smcg_pkg::SMCG_STARTUP:
            begin
                if (r.cnt == smcg_pkg::FAST_CLOCK_SOURCE_SELECT_FUSES_ZERO)
                begin
                    if (r.irq_wake)
                    begin
                        next_r.st  = smcg_pkg::SMCG_HALT;
                        next_r.cnt = smcg_pkg::IRQ_HALT_CYCLES - 8'h01;
                        // Outside Idle, a level that dropped early wakes but raises nothing
                        next_r.irq_raise = !(w.level_irq == 1'b0 && r.mode != smcg_pkg::MODE_IDLE
                            && !timer_wake && !watchdog_irq_wake && !r.ext_tw[2]
                            && !w.pin_change);
                    end
                    else
                    begin
                        next_r.st         = smcg_pkg::SMCG_ACTIVE;
                        next_r.cpu_resume = 1'b1;
                    end
                end
                else
                begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            smcg_pkg::SMCG_HALT:
            begin
                if (r.cnt == smcg_pkg::COUNT_RESET)
                begin
                    next_r.st         = smcg_pkg::SMCG_ACTIVE;
                    next_r.cpu_resume = 1'b1;
                end
                else
                begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            default:
            begin
                next_r.st = smcg_pkg::SMCG_ACTIVE;
            end
        endcase

        // Clock domains follow the mode only while truly asleep
        if (next_r.st == smcg_pkg::SMCG_SLEEP)
        begin
            next_r.clk_cpu_en   = 1'b0;
            next_r.clk_flash_en = 1'b0;
            next_r.clk_io_en    = (next_r.mode == smcg_pkg::MODE_IDLE);
            next_r.clk_adc_en   = (next_r.mode == smcg_pkg::MODE_IDLE)
                || (next_r.mode == smcg_pkg::MODE_NOISE);
            next_r.clk_async_en = async_timer_enable && async_timer_async
                && (next_r.mode != smcg_pkg::MODE_PDOWN)
                && (next_r.mode != smcg_pkg::MODE_STANDBY);
            // Power-down stops the oscillator unless Standby, a synchronously clocked Power-save timer or debug keeps it
            next_r.main_osc_en  = (next_r.mode == smcg_pkg::MODE_IDLE)
                || (next_r.mode == smcg_pkg::MODE_NOISE)
                || (next_r.mode == smcg_pkg::MODE_STANDBY)
                || (next_r.mode == smcg_pkg::MODE_EXTSTBY)
                || (next_r.mode == smcg_pkg::MODE_PSAVE && async_timer_enable && !async_timer_async)
                || debug_keep;
            next_r.timer_osc_en = async_timer_enable && async_timer_async
                && (next_r.mode != smcg_pkg::MODE_PDOWN)
                && (next_r.mode != smcg_pkg::MODE_STANDBY);
            next_r.timer_sync_clk_en = async_timer_enable && !async_timer_async
                && ((next_r.mode == smcg_pkg::MODE_PSAVE)
                || (next_r.mode == smcg_pkg::MODE_EXTSTBY));
        end
        else
        begin
            next_r.clk_cpu_en        = (next_r.st == smcg_pkg::SMCG_ACTIVE);
            next_r.clk_flash_en      = (next_r.st == smcg_pkg::SMCG_ACTIVE);
            next_r.clk_io_en         = 1'b1;
            next_r.clk_adc_en        = 1'b1;
            next_r.clk_async_en      = async_timer_enable && async_timer_async;
            next_r.main_osc_en       = 1'b1;
            next_r.timer_osc_en      = async_timer_enable && async_timer_async;
            next_r.timer_sync_clk_en = async_timer_enable && !async_timer_async;
        end

        // Peripheral gating: bits act while I/O clock runs, other modes stop all but the async timer
        for (int i = 0; i < smcg_pkg::PERIPH_COUNT; i++)
        begin
            next_r.periph_clk_en[i]    = next_r.clk_io_en && !power_reduction_bits[i];
            next_r.periph_access_ok[i] = periph_access[i] && !power_reduction_bits[i];
        end
        // Async timer keeps counting on its own clock regardless of gating
        if (async_timer_async)
        begin
            next_r.periph_clk_en[smcg_pkg::PRR_TIM2_BIT] = next_r.clk_async_en;
        end

        // Comparator, brown-out and input buffers follow the mode being entered, so the entry edge already sees it
        next_deep = (next_r.mode != smcg_pkg::MODE_IDLE) && (next_r.mode != smcg_pkg::MODE_NOISE);
        next_r.converter_on  = converter_enable && !power_reduction_bits[smcg_pkg::PRR_ADC_BIT];
        next_r.conv_prev     = next_r.converter_on;
        if (next_r.converter_on && !r.conv_prev)
        begin
            next_r.conv_ext = 1'b1;
        end
        else if (converter_done)
        begin
            next_r.conv_ext = 1'b0;
        end
        next_r.comparator_on = comparator_enable
            && !((next_r.st == smcg_pkg::SMCG_SLEEP) && next_deep);
        next_r.brownout_on   = brownout_level_fuses
            && !((next_r.st == smcg_pkg::SMCG_SLEEP) && next_deep && brownout_sleep_off);
        // Reference stays up for a comparator that uses it, even once sleep stops the comparator
        next_r.vref_on       = next_r.brownout_on
            || (comparator_enable && comparator_uses_ref) || next_r.converter_on;
        // Wake pins are watched by the synchroniser, not through these buffers
        next_r.input_buf_en  = !((next_r.st == smcg_pkg::SMCG_SLEEP) && next_deep);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r                   <= '0;
            r.st                <= smcg_pkg::SMCG_ACTIVE;
            r.clk_cpu_en        <= 1'b1;
            r.clk_flash_en      <= 1'b1;
            r.clk_io_en         <= 1'b1;
            r.clk_adc_en        <= 1'b1;
            r.main_osc_en       <= 1'b1;
            r.periph_clk_en     <= '1;
            r.input_buf_en      <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign clk_cpu_en         = r.clk_cpu_en;
    assign clk_flash_en       = r.clk_flash_en;
    assign clk_io_en          = r.clk_io_en;
    assign clk_adc_en         = r.clk_adc_en;
    assign clk_async_en       = r.clk_async_en;
    assign main_osc_en        = r.main_osc_en;
    assign timer_osc_en       = r.timer_osc_en;
    assign timer_sync_clk_en  = r.timer_sync_clk_en;
    assign periph_clk_en      = r.periph_clk_en;
    assign periph_access_ok   = r.periph_access_ok;
    assign converter_on       = r.converter_on;
    assign converter_extended = r.conv_ext;
    assign comparator_on      = r.comparator_on;
    assign brownout_on        = r.brownout_on;
    assign vref_on            = r.vref_on;
    assign input_buf_en       = r.input_buf_en;
    assign irq_raise          = r.irq_raise;
    assign cpu_resume         = r.cpu_resume;
    assign active_mode        = r.mode;
endmodule

// ==== hw/smcg_pkg.sv ====
package smcg_pkg;
    // Sleep mode encodings
    localparam logic [2:0] MODE_IDLE     = 3'h0;
    localparam logic [2:0] MODE_NOISE    = 3'h1;
    localparam logic [2:0] MODE_PDOWN    = 3'h2;
    localparam logic [2:0] MODE_PSAVE    = 3'h3;
    localparam logic [2:0] MODE_STANDBY  = 3'h6;
    localparam logic [2:0] MODE_EXTSTBY  = 3'h7;
    localparam int         PERIPH_COUNT  = 8;
    localparam int         PRR_ADC_BIT   = 0;
    localparam int         PRR_TIM2_BIT  = 6;
    // Standby wake time and interrupt halt, in cycles
    localparam logic [7:0] STANDBY_WAKE_CYCLES = 8'h06;
    localparam logic [7:0] IRQ_HALT_CYCLES     = 8'h04;
    localparam logic [7:0] FAST_CLOCK_SOURCE_SELECT_FUSES_ZERO     = 8'h00;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN      = 4'h8;
    localparam int         STARTUP_SCALE_SHIFT = 4;
    localparam logic [1:0] SYNC_RESET          = 2'h0;
    localparam logic [7:0] COUNT_RESET         = 8'h00;

    typedef enum logic [2:0] {
        SMCG_ACTIVE,
        SMCG_SLEEP,
        SMCG_STARTUP,
        SMCG_HALT
    } smcg_state_e;
endpackage

// ==== hw/smcg_wake_if.sv ====
`timescale 1ns/1ps
interface smcg_wake_if;
    logic [2:0] mode;
    logic       asleep;
    logic       timer_async;
    logic       level_irq_raw;
    logic       pin_change_raw;
    logic       level_irq;
    logic       pin_change;
    logic       wake_hit;

    modport filt
    (
        input  mode,
        input  asleep,
        input  timer_async,
        input  level_irq_raw,
        input  pin_change_raw,
        output level_irq,
        output pin_change,
        output wake_hit
    );

    modport ctl
    (
        output mode,
        output asleep,
        output timer_async,
        output level_irq_raw,
        output pin_change_raw,
        input  level_irq,
        input  pin_change,
        input  wake_hit
    );
endinterface

// ==== hw/smcg_pin_sync.sv ====
`timescale 1ns/1ps
// ****************************************
// Pin synchroniser for wake pins
// ****************************************
module smcg_pin_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    smcg_wake_if.filt w
);
    typedef struct packed {
        logic [2:0] lvl;
        logic [2:0] pc;
        logic       lvl_q;
        logic       pc_q;
    } smcg_sync_s;

    smcg_sync_s r;
    smcg_sync_s next_r;

    always_comb
    begin
        next_r     = r;
        next_r.lvl = {r.lvl[1:0], w.level_irq_raw};
        next_r.pc  = {r.pc[1:0], w.pin_change_raw};
        // Change counts only once stages two and three agree
        if (r.lvl[1] == r.lvl[2])
        begin
            next_r.lvl_q = r.lvl[2];
        end
        if (r.pc[1] == r.pc[2])
        begin
            next_r.pc_q = r.pc[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign w.level_irq  = r.lvl_q;
    assign w.pin_change = r.pc_q;
    // Level and pin-change wake sources only reach the wake logic while asleep
    assign w.wake_hit   = w.asleep && (r.lvl_q || r.pc_q);
endmodule

// ==== tb/smcg_props.sv ====
`timescale 1ns/1ps
// ***
// Sleep controller checks
// ***
module smcg_props
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [2:0] sleep_mode_select,
    input wire logic       sleep_enable_bit,
    input wire logic       sleep_instr,
    input wire logic [7:0] power_reduction_bits,
    input wire logic       watchdog_reset_wake,
    input wire logic       clk_cpu_en,
    input wire logic       clk_io_en,
    input wire logic       clk_adc_en,
    input wire logic       clk_async_en,
    input wire logic       async_timer_async,
    input wire logic [7:0] periph_clk_en,
    input wire logic       irq_raise,
    input wire logic       cpu_resume,
    input wire logic [2:0] active_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Only a sleep taken while running counts, idle also drops the cpu clock
    wire logic sl = sleep_instr && sleep_enable_bit && clk_cpu_en;
    a_reserved_noop: assert property (sl && sleep_mode_select[2:1] == 2'h2 |=> clk_cpu_en)
        else $error("reserved sleep");
    a_pdown_entry: assert property (sl && sleep_mode_select == 3'h2 |=> !clk_cpu_en && !clk_io_en && !clk_adc_en)
        else $error("power-down entry");
    a_idle_entry: assert property (sl && sleep_mode_select == 3'h0 |=> !clk_cpu_en && clk_io_en && clk_adc_en)
        else $error("idle entry");
    a_standby_wake: assert property (!clk_cpu_en && active_mode == 3'h6 && $rose(watchdog_reset_wake) |-> ##[1:9] cpu_resume)
        else $error("standby wake slow");
    a_irq_halt: assert property (irq_raise |-> ##[4:5] cpu_resume) else $error("irq halt length");
    a_resume_pulse: assert property (cpu_resume |=> !cpu_resume) else $error("resume pulse");
    a_prr_gate: assert property (clk_cpu_en && power_reduction_bits[3] |=> !periph_clk_en[3]) else $error("gated clock");
    a_deep_gated: assert property (!clk_io_en && !clk_adc_en |->
        periph_clk_en == {1'b0, async_timer_async && clk_async_en, 6'h00}) else $error("deep clock");
endmodule

// ==== tb/smcg_core_model.sv ====
`timescale 1ns/1ps
// ***
// Core side of the sleep handshake
// ***
module smcg_core_model
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] mode,
    output logic            sleep_instr = 1'b0,
    output logic            sleep_enable_bit = 1'b0,
    output logic [2:0]      sleep_mode_select = 3'h0
);
    // Enable leads the instruction by a cycle so a stray sleep is never armed
    always @(negedge clk)
    begin
        sleep_enable_bit  <= go;
        sleep_instr       <= go && sleep_enable_bit && !sleep_instr;
        sleep_mode_select <= mode;
    end
endmodule

// ==== tb/smcg_top_tb.sv ====
`timescale 1ns/1ps
// ***
// Sleep controller bench
// ***
module smcg_top_tb;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            go = 1'b0;
    logic [2:0]      mode = 3'h0;
    logic [31:0]     cfg = '0;
    logic [7:0]      wk = '0;
    logic            irq_seen;
    int              err_total = 0;
    int              n_compared = 0;
    int              seed = 37;
    wire logic       si, se, cpu, io, adc, osc, cmp, ib, irq, res, fl, asy, brownout_detector, vref;
    wire logic [2:0] sm, am;
    wire logic [7:0] pclk, pok;
    always #5 clk = ~clk;
    smcg_core_model core_u (.clk(clk), .go(go), .mode(mode), .sleep_instr(si), .sleep_enable_bit(se),
        .sleep_mode_select(sm));
    smcg_top dut_u (.clk(clk), .rst_n(rst_n), .sleep_mode_select(sm), .sleep_enable_bit(se), .sleep_instr(si),
        .power_reduction_bits(cfg[7:0]), .periph_access(cfg[15:8]), .clock_source_select_fuses({cfg[31], 3'h0}),
        .startup_time_fuses(cfg[17:16]), .brownout_level_fuses(cfg[18]), .brownout_sleep_off(cfg[19]),
        .debug_system_fuse(cfg[20]), .scan_port_enable_fuse(cfg[21]), .debug_port_disable(cfg[22]),
        .global_irq_enable(cfg[23]), .async_timer_interrupt_mask(cfg[25:24]), .async_timer_event({1'b0, wk[7]}),
        .async_timer_async(cfg[26]), .async_timer_enable(cfg[27]), .converter_enable(cfg[28]), .converter_done(1'b0),
        .comparator_enable(cfg[29]), .comparator_uses_ref(cfg[30]), .ext_reset_wake(wk[3]), .watchdog_reset_wake(wk[0]),
        .watchdog_irq_wake(wk[5]), .brownout_reset_wake(wk[4]), .two_wire_match(wk[6]), .mem_ready_irq(1'b0),
        .ext_level_irq(wk[1]), .pin_change_irq(wk[2]), .clk_cpu_en(cpu), .clk_flash_en(fl), .clk_io_en(io),
        .clk_adc_en(adc), .clk_async_en(asy), .main_osc_en(osc), .timer_osc_en(), .timer_sync_clk_en(),
        .periph_clk_en(pclk), .periph_access_ok(pok), .converter_on(), .converter_extended(), .comparator_on(cmp),
        .brownout_on(brownout_detector), .vref_on(vref), .input_buf_en(ib), .irq_raise(irq), .cpu_resume(res), .active_mode(am));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One sleep and wake; brief drops the wake level well before start-up ends
    task automatic trip(input int src, input bit brief);
        int   n;
        int   lim;
        logic ok;
        logic dbg;
        logic bx;
        logic [7:0] pe;
        ok = !(mode inside {3'h4, 3'h5}) && (cfg[31] || !mode[2]);
        dbg = cfg[20] && cfg[21] && !cfg[22];
        bx = cfg[18] && !(ok && mode > 3'h1 && cfg[19]);
        // The start-up count is eight bits wide, so the crystal fuse bit drops out of it
        lim = (mode inside {3'h2, 3'h3}) ? 16 * cfg[17:16] + 6 : 6;
        // An asynchronously clocked timer runs on its own clock, whatever its gate bit says
        pe = ~cfg[7:0];
        if (cfg[26])
            pe[6] = cfg[27];
        repeat (2) @(negedge clk);
        check("pclk", pclk, pe);
        check("access", pok, cfg[15:8] & ~cfg[7:0]);
        go <= 1'b1;
        repeat (2) @(negedge clk);
        go <= 1'b0;
        repeat (3) @(negedge clk);
        check("cpu", cpu, !ok);
        check("io", io, !ok || mode == 3'h0);
        check("adc", adc, !ok || mode < 3'h2);
        check("osc", osc, !ok || mode[2] || mode < 3'h2 || dbg || (mode == 3'h3 && cfg[27] && !cfg[26]));
        check("cmp", cmp, cfg[29] && (!ok || mode < 3'h2));
        check("flash", fl, !ok);
        check("async", asy, cfg[26] && cfg[27] && !(ok && mode inside {3'h2, 3'h6}));
        check("bod", brownout_detector, bx);
        check("vref", vref, bx || (cfg[29] && cfg[30]) || (cfg[28] && !cfg[0]));
        check("ibuf", ib, !ok || mode < 3'h2);
        if (ok && mode != 3'h0)
            pe = {1'b0, cfg[26] && cfg[27] && !(mode inside {3'h2, 3'h6}), 6'h00};
        check("pclk_sleep", pclk, pe);
        if (!ok)
            return;
        check("mode", am, mode);
        irq_seen = 1'b0;
        n = 0;
        wk[src] <= 1'b1;
        while (res !== 1'b1 && n < 900)
        begin
            @(negedge clk);
            irq_seen |= irq;
            n++;
            if (brief && n == 3)
                wk <= '0;
        end
        wk <= '0;
        if (n == 900)
        begin
            err_total++;
            tally_and_finish;
        end
        check("wake_time", n >= lim && n <= lim + 12, 1'b1);
        check("irq", irq_seen, !(src inside {0, 3, 4}) && !brief);
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            cfg = $random(seed);
            mode = 3'(i);
            trip({$random(seed)} % 7, 1'b0);
        end
        // Crystal standby woken by a watchdog reset, then a timer event in Power-save
        cfg[31] = 1'b1;
        mode = 3'h6;
        trip(0, 1'b0);
        cfg[27:23] = 5'h1F;
        mode = 3'h3;
        trip(7, 1'b0);
        mode = 3'h2;
        trip(1, 1'b1);
        tally_and_finish;
    end
endmodule
bind smcg_top smcg_props chk_u (.clk(clk), .rst_n(rst_n), .sleep_mode_select(sleep_mode_select),
    .sleep_enable_bit(sleep_enable_bit), .sleep_instr(sleep_instr), .power_reduction_bits(power_reduction_bits),
    .watchdog_reset_wake(watchdog_reset_wake), .clk_cpu_en(clk_cpu_en), .clk_io_en(clk_io_en),
    .clk_adc_en(clk_adc_en), .clk_async_en(clk_async_en), .async_timer_async(async_timer_async),
    .periph_clk_en(periph_clk_en), .irq_raise(irq_raise), .cpu_resume(cpu_resume),
    .active_mode(active_mode));
